// File: hw/eac_pkg.sv
package eac_pkg;

    // register offsets on the core i/o port
    localparam logic [5:0] EAC_OFS_SCRATCH_ZERO = 6'h14;
    localparam logic [5:0] EAC_OFS_SCRATCH_ONE = 6'h15;
    localparam logic [5:0] EAC_OFS_SCRATCH_TWO = 6'h16;
    localparam logic [5:0] EAC_OFS_CONTROL = 6'h1c;
    localparam logic [5:0] EAC_OFS_DATA = 6'h1d;
    localparam logic [5:0] EAC_OFS_ADDR_LOW = 6'h1e;

    // control register fields
    localparam int EAC_BIT_MODE_HI = 5;
    localparam int EAC_BIT_MODE_LO = 4;
    localparam int EAC_BIT_RIE = 3;
    localparam int EAC_BIT_ARM = 2;
    localparam int EAC_BIT_PSTART = 1;
    localparam int EAC_BIT_RSTROBE = 0;

    // reset values
    localparam logic [7:0] EAC_BYTE_RESET = 8'h00;
    localparam logic [7:0] EAC_READ_UNMAPPED = 8'h00;
    localparam logic [1:0] EAC_RSVD_BITS = 2'h0;
    localparam logic EAC_STROBE_READBACK = 1'b0;

    // programming modes, encoded 00 atomic, 01 erase, 10 write, 11 reserved
    typedef enum logic [1:0] {
        EAC_MODE_ATOMIC,
        EAC_MODE_ERASE,
        EAC_MODE_WRITE,
        EAC_MODE_RSVD
    } eac_mode_type;

    // memory size
    localparam int EAC_MEM_BYTES = 256;

    // timing: cpu clock and the programming oscillator
    localparam int EAC_CLK_HZ = 20_000_000;
    localparam int EAC_OSC_MHZ = 8;
    localparam int EAC_ATOMIC_TIME_US = 3400;
    localparam int EAC_SPLIT_TIME_US = 1800;
    localparam int EAC_ATOMIC_TICKS = EAC_ATOMIC_TIME_US * EAC_OSC_MHZ;
    localparam int EAC_SPLIT_TICKS = EAC_SPLIT_TIME_US * EAC_OSC_MHZ;

    // cycle counts on the cpu clock
    localparam logic [2:0] EAC_ARM_CYCLES = 3'h4;
    localparam logic [2:0] EAC_PROG_STALL_CYCLES = 3'h2;
    localparam logic [2:0] EAC_READ_STALL_CYCLES = 3'h4;
    localparam logic [2:0] EAC_CNT_ZERO = 3'h0;
    localparam logic [2:0] EAC_CNT_ONE = 3'h1;

endpackage : eac_pkg

// File: hw/eac_prog_timer.sv
`timescale 1ns/1ps
`default_nettype none

module eac_prog_timer #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic por_resetn,
    input wire logic start,
    input wire logic [CNT_W-1:0] load_ticks,
    input wire logic osc_tick,
    output logic busy,
    output logic done
);

    logic [CNT_W-1:0] remain_r;
    logic done_r;

    // chip reset does not touch the count, so an operation runs to its end
    always_ff @(posedge clk) begin
        if (!por_resetn) begin
            remain_r <= '0;
        end else if (start && (remain_r == '0)) begin
            remain_r <= load_ticks;
        end else if (osc_tick && (remain_r != '0)) begin
            remain_r <= remain_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (!por_resetn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= osc_tick && (remain_r == {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end

    assign busy = (remain_r != '0);
    assign done = done_r;

endmodule : eac_prog_timer

`default_nettype wire

// File: hw/eac_core.sv
`timescale 1ns/1ps
`default_nettype none

module eac_core
    import eac_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int ATOMIC_TICKS = EAC_ATOMIC_TICKS,
    parameter int SPLIT_TICKS = EAC_SPLIT_TICKS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic por_resetn,
    input wire logic [5:0] io_addr,
    input wire logic io_wr_en,
    input wire logic io_rd_en,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic core_irq_global,
    output logic ready_irq,
    output logic cpu_stall,
    input wire logic flash_prog_req,
    output logic flash_prog_grant,
    output logic flash_prog_blocked,
    input wire logic osc_tick,
    output logic [7:0] ee_addr,
    input wire logic [7:0] ee_rdata,
    output logic ee_rd_stb,
    output logic [7:0] ee_wdata,
    output logic ee_erase_en,
    output logic ee_write_en,
    output logic ee_prog_done
);

    if (CNT_W < 2 || CNT_W > 31) begin : g_bad_width
        $error("counter width out of range");
    end
    if (ATOMIC_TICKS < 1 || ATOMIC_TICKS >= (1 << CNT_W)) begin : g_bad_atomic
        $error("atomic tick count does not fit the counter");
    end
    if (SPLIT_TICKS < 1 || SPLIT_TICKS >= (1 << CNT_W)) begin : g_bad_split
        $error("split tick count does not fit the counter");
    end

    localparam logic [CNT_W-1:0] ATOMIC_LOAD = CNT_W'(ATOMIC_TICKS);
    localparam logic [CNT_W-1:0] SPLIT_LOAD = CNT_W'(SPLIT_TICKS);

    logic [7:0] nvm_location_index_low_r;
    logic [7:0] nvm_byte_buffer_r;
    logic [7:0] prog_data_r;
    eac_mode_type prog_mode_field_r;
    eac_mode_type op_mode_r;
    logic ready_irq_enable_r;
    logic master_prog_arm_r;
    logic [2:0] arm_cnt_r;
    logic [2:0] stall_cnt_r;
    logic [7:0] scratch_zero_r;
    logic [7:0] scratch_one_r;
    logic [7:0] scratch_two_r;
    logic [7:0] io_rdata_r;
    logic [7:0] rdata_nxt;
    logic ee_rd_stb_r;
    logic prog_start_busy;
    logic ctrl_wr;
    logic start_prog;
    logic start_read;
    logic [CNT_W-1:0] load_ticks;
    eac_mode_type mode_wr;

    assign ctrl_wr = io_wr_en && (io_addr == EAC_OFS_CONTROL);
    assign mode_wr = eac_mode_type'({io_wdata[EAC_BIT_MODE_HI], io_wdata[EAC_BIT_MODE_LO]});

    // program start needs a live arm, an idle array and a real mode
    assign start_prog = ctrl_wr && io_wdata[EAC_BIT_PSTART] && master_prog_arm_r
        && !prog_start_busy && (prog_mode_field_r != EAC_MODE_RSVD);

    // read refused while busy or when a program start wins the same write
    assign start_read = ctrl_wr && io_wdata[EAC_BIT_RSTROBE] && !prog_start_busy
        && !start_prog;

    always_comb begin
        case (prog_mode_field_r)
            EAC_MODE_ATOMIC: load_ticks = ATOMIC_LOAD;
            EAC_MODE_ERASE: load_ticks = SPLIT_LOAD;
            EAC_MODE_WRITE: load_ticks = SPLIT_LOAD;
            default: load_ticks = SPLIT_LOAD;
        endcase
    end

    // busy flag, counted on the programming oscillator
    eac_prog_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .clk(clk),
        .por_resetn(por_resetn),
        .start(start_prog),
        .load_ticks(load_ticks),
        .osc_tick(osc_tick),
        .busy(prog_start_busy),
        .done(ee_prog_done)
    );

    // address register
    always_ff @(posedge clk) begin
        if (!por_resetn) begin
            nvm_location_index_low_r <= EAC_BYTE_RESET;
        end else if (!resetn) begin
            if (!prog_start_busy) begin
                nvm_location_index_low_r <= EAC_BYTE_RESET;
            end
        end else if (io_wr_en && (io_addr == EAC_OFS_ADDR_LOW) && !prog_start_busy) begin
            nvm_location_index_low_r <= io_wdata;
        end
    end

    // data register: read result has priority over a software write
    always_ff @(posedge clk) begin
        if (!resetn || !por_resetn) begin
            nvm_byte_buffer_r <= EAC_BYTE_RESET;
        end else if (start_read) begin
            nvm_byte_buffer_r <= ee_rdata;
        end else if (io_wr_en && (io_addr == EAC_OFS_DATA)) begin
            nvm_byte_buffer_r <= io_wdata;
        end
    end

    // byte and mode held for the array across the whole operation
    always_ff @(posedge clk) begin
        if (!por_resetn) begin
            prog_data_r <= EAC_BYTE_RESET;
            op_mode_r <= EAC_MODE_ATOMIC;
        end else if (start_prog) begin
            prog_data_r <= nvm_byte_buffer_r;
            op_mode_r <= prog_mode_field_r;
        end
    end

    // mode field
    always_ff @(posedge clk) begin
        if (!por_resetn) begin
            prog_mode_field_r <= EAC_MODE_ATOMIC;
        end else if (!resetn) begin
            if (!prog_start_busy) begin
                prog_mode_field_r <= EAC_MODE_ATOMIC;
            end
        end else if (ctrl_wr && !prog_start_busy && !start_prog) begin
            prog_mode_field_r <= mode_wr;
        end
    end

    // ready interrupt enable
    always_ff @(posedge clk) begin
        if (!resetn || !por_resetn) begin
            ready_irq_enable_r <= 1'b0;
        end else if (ctrl_wr) begin
            ready_irq_enable_r <= io_wdata[EAC_BIT_RIE];
        end
    end

    // arm window: set by software, cleared by hardware after four cycles
    always_ff @(posedge clk) begin
        if (!resetn || !por_resetn) begin
            master_prog_arm_r <= 1'b0;
            arm_cnt_r <= EAC_CNT_ZERO;
        end else if (start_prog) begin
            master_prog_arm_r <= 1'b0;
            arm_cnt_r <= EAC_CNT_ZERO;
        end else if (ctrl_wr && io_wdata[EAC_BIT_ARM]) begin
            master_prog_arm_r <= 1'b1;
            arm_cnt_r <= EAC_ARM_CYCLES;
        end else if (arm_cnt_r != EAC_CNT_ZERO) begin
            arm_cnt_r <= arm_cnt_r - EAC_CNT_ONE;
            if (arm_cnt_r == EAC_CNT_ONE) begin
                master_prog_arm_r <= 1'b0;
            end
        end
    end

    // core stall counter
    always_ff @(posedge clk) begin
        if (!resetn || !por_resetn) begin
            stall_cnt_r <= EAC_CNT_ZERO;
        end else if (start_prog) begin
            stall_cnt_r <= EAC_PROG_STALL_CYCLES;
        end else if (start_read) begin
            stall_cnt_r <= EAC_READ_STALL_CYCLES;
        end else if (stall_cnt_r != EAC_CNT_ZERO) begin
            stall_cnt_r <= stall_cnt_r - EAC_CNT_ONE;
        end
    end

    assign cpu_stall = (stall_cnt_r != EAC_CNT_ZERO);

    // read strobe toward the array
    always_ff @(posedge clk) begin
        if (!resetn || !por_resetn) begin
            ee_rd_stb_r <= 1'b0;
        end else begin
            ee_rd_stb_r <= start_read;
        end
    end

    // scratch registers
    always_ff @(posedge clk) begin
        if (!resetn || !por_resetn) begin
            scratch_zero_r <= EAC_BYTE_RESET;
            scratch_one_r <= EAC_BYTE_RESET;
            scratch_two_r <= EAC_BYTE_RESET;
        end else if (io_wr_en) begin
            if (io_addr == EAC_OFS_SCRATCH_ZERO) begin
                scratch_zero_r <= io_wdata;
            end else if (io_addr == EAC_OFS_SCRATCH_ONE) begin
                scratch_one_r <= io_wdata;
            end else if (io_addr == EAC_OFS_SCRATCH_TWO) begin
                scratch_two_r <= io_wdata;
            end
        end
    end

    // read mux
    always_comb begin
        if (io_addr == EAC_OFS_CONTROL) begin
            rdata_nxt = {EAC_RSVD_BITS, prog_mode_field_r, ready_irq_enable_r,
                master_prog_arm_r, prog_start_busy, EAC_STROBE_READBACK};
        end else if (io_addr == EAC_OFS_DATA) begin
            rdata_nxt = nvm_byte_buffer_r;
        end else if (io_addr == EAC_OFS_ADDR_LOW) begin
            rdata_nxt = nvm_location_index_low_r;
        end else if (io_addr == EAC_OFS_SCRATCH_ZERO) begin
            rdata_nxt = scratch_zero_r;
        end else if (io_addr == EAC_OFS_SCRATCH_ONE) begin
            rdata_nxt = scratch_one_r;
        end else if (io_addr == EAC_OFS_SCRATCH_TWO) begin
            rdata_nxt = scratch_two_r;
        end else begin
            rdata_nxt = EAC_READ_UNMAPPED;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || !por_resetn) begin
            io_rdata_r <= EAC_READ_UNMAPPED;
        end else if (io_rd_en) begin
            io_rdata_r <= rdata_nxt;
        end
    end

    assign io_rdata = io_rdata_r;

    // interrupt and flash programming block
    assign ready_irq = ready_irq_enable_r && core_irq_global && !prog_start_busy;
    assign flash_prog_blocked = prog_start_busy;
    assign flash_prog_grant = flash_prog_req && !prog_start_busy;

    // array side
    assign ee_addr = nvm_location_index_low_r;
    assign ee_rd_stb = ee_rd_stb_r;
    assign ee_wdata = prog_data_r;
    assign ee_erase_en = prog_start_busy && (op_mode_r != EAC_MODE_WRITE);
    assign ee_write_en = prog_start_busy && (op_mode_r != EAC_MODE_ERASE);

endmodule : eac_core

`default_nettype wire

// File: dv/eac_array_model.sv
`timescale 1ns/1ps
`default_nettype none
module eac_array_model #(
    parameter int TICK_DIV = 3
) (
    input wire logic clk,
    input wire logic [7:0] ee_addr,
    output logic [7:0] ee_rdata,
    input wire logic [7:0] ee_wdata,
    input wire logic ee_erase_en,
    input wire logic ee_write_en,
    input wire logic ee_prog_done,
    output logic osc_tick
);
    logic [7:0] mem [256];
    logic [7:0] div_r;
    logic er_r;
    logic wr_r;
    initial begin
        div_r = 8'h00;
        osc_tick = 1'b0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
    end
    assign ee_rdata = mem[ee_addr];
    always @(posedge clk) begin
        div_r <= (div_r == 8'(TICK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
        osc_tick <= (div_r == 8'h00);
        if (ee_erase_en | ee_write_en) begin
            er_r <= ee_erase_en;
            wr_r <= ee_write_en;
        end
        // unerased write-only cells end up as the and of old and new
        if (ee_prog_done) begin
            mem[ee_addr] <= (er_r ? 8'hff : mem[ee_addr]) & (wr_r ? ee_wdata : 8'hff);
        end
    end
endmodule : eac_array_model
`default_nettype wire

// File: dv/eac_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module eac_core_sva
    import eac_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic por_resetn,
    input wire logic [5:0] io_addr,
    input wire logic io_wr_en,
    input wire logic [7:0] io_wdata,
    input wire logic core_irq_global,
    input wire logic ready_irq,
    input wire logic cpu_stall,
    input wire logic flash_prog_req,
    input wire logic flash_prog_grant,
    input wire logic flash_prog_blocked,
    input wire logic [7:0] ee_addr,
    input wire logic [7:0] ee_wdata,
    input wire logic ee_rd_stb,
    input wire logic ee_erase_en,
    input wire logic ee_write_en,
    input wire logic ee_prog_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn || !por_resetn);
    logic rd_go;
    assign rd_go = io_wr_en && io_addr == EAC_OFS_CONTROL && io_wdata[0] && !io_wdata[1]
        && !flash_prog_blocked;
    sequence s_read_stall;
        cpu_stall [*4] ##1 !cpu_stall;
    endsequence
    sequence s_prog_stall;
        cpu_stall [*2] ##1 !cpu_stall;
    endsequence
    a_read_stall: assert property (rd_go |=> s_read_stall) else $error("read stall wrong");
    a_read_strobe: assert property (rd_go |=> ee_rd_stb) else $error("no read strobe");
    a_prog_stall: assert property ($rose(flash_prog_blocked) |-> s_prog_stall)
        else $error("program stall wrong");
    a_irq_level: assert property (ready_irq |-> core_irq_global && !flash_prog_blocked)
        else $error("ready irq while busy or masked");
    a_flash_grant: assert property (flash_prog_grant == (flash_prog_req && !flash_prog_blocked))
        else $error("flash grant wrong");
    a_done_pulse: assert property (ee_prog_done |-> !flash_prog_blocked && $past(flash_prog_blocked))
        else $error("done without busy end");
    a_addr_hold: assert property (flash_prog_blocked && $past(flash_prog_blocked) |->
        $stable(ee_addr)) else $error("address moved");
    a_data_hold: assert property (flash_prog_blocked && $past(flash_prog_blocked) |->
        $stable(ee_wdata)) else $error("data moved");
    a_en_busy: assert property (ee_erase_en || ee_write_en |-> flash_prog_blocked)
        else $error("array enable while idle");
endmodule : eac_core_sva
bind eac_core eac_core_sva u_sva (.clk(clk), .resetn(resetn), .por_resetn(por_resetn),
    .io_addr(io_addr), .io_wr_en(io_wr_en), .io_wdata(io_wdata),
    .core_irq_global(core_irq_global), .ready_irq(ready_irq), .cpu_stall(cpu_stall),
    .flash_prog_req(flash_prog_req), .flash_prog_grant(flash_prog_grant),
    .flash_prog_blocked(flash_prog_blocked), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
    .ee_rd_stb(ee_rd_stb), .ee_erase_en(ee_erase_en), .ee_write_en(ee_write_en),
    .ee_prog_done(ee_prog_done));
`default_nettype wire

// File: dv/eeprom_access_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module eeprom_access_controller_tb
    import eac_pkg::*;
;
    logic clk, resetn, por_resetn, io_wr_en, io_rd_en, irq_g, freq, ready_irq, cpu_stall;
    logic grant, blocked, osc_tick, ee_rd_stb, er_en, wr_en, done;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata, ee_addr, ee_rdata, ee_wdata;
    int miscompares = 0;
    int n_tests = 0;
    logic [21:0] rows [7] = '{{6'h14, 8'h5a, 8'h5a}, {6'h15, 8'ha5, 8'ha5}, {6'h16, 8'hff, 8'hff},
        {6'h1d, 8'h3c, 8'h3c}, {6'h1e, 8'hff, 8'hff}, {6'h1c, 8'hc8, 8'h08}, {6'h1c, 8'h00, 8'h00}};
    eac_core #(.ATOMIC_TICKS(20), .SPLIT_TICKS(10)) u_dut (.clk(clk), .resetn(resetn),
        .por_resetn(por_resetn), .io_addr(io_addr), .io_wr_en(io_wr_en), .io_rd_en(io_rd_en),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .core_irq_global(irq_g), .ready_irq(ready_irq),
        .cpu_stall(cpu_stall), .flash_prog_req(freq), .flash_prog_grant(grant),
        .flash_prog_blocked(blocked), .osc_tick(osc_tick), .ee_addr(ee_addr),
        .ee_rdata(ee_rdata), .ee_rd_stb(ee_rd_stb), .ee_wdata(ee_wdata), .ee_erase_en(er_en),
        .ee_write_en(wr_en), .ee_prog_done(done));
    eac_array_model u_mem (.clk(clk), .ee_addr(ee_addr), .ee_rdata(ee_rdata),
        .ee_wdata(ee_wdata), .ee_erase_en(er_en), .ee_write_en(wr_en),
        .ee_prog_done(done), .osc_tick(osc_tick));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr_en <= 1'b1;
        @(posedge clk);
        io_wr_en <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        io_addr <= a;
        io_rd_en <= 1'b1;
        @(posedge clk);
        io_rd_en <= 1'b0;
        #1;
        `CHK(io_rdata, e)
    endtask : rd
    task automatic start(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d);
        wr(EAC_OFS_CONTROL, {2'h0, m, 4'h0});
        wr(EAC_OFS_ADDR_LOW, a);
        wr(EAC_OFS_DATA, d);
        wr(EAC_OFS_CONTROL, {2'h0, m, 4'h4});
        wr(EAC_OFS_CONTROL, {2'h0, m, 4'h6});
        `CHK({blocked, cpu_stall}, 2'h3)
        `CHK(ee_wdata, d)
        `CHK({er_en, wr_en}, {m != 2'h2, m != 2'h1})
    endtask : start
    task automatic finish(input int ticks);
        int n;
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK((n > ticks * 3 - 25 && n < ticks * 3 + 4), 1'b1)
    endtask : finish
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task automatic prog(input logic [1:0] m, input int t, input logic [7:0] d, input logic [7:0] e);
        start(m, 8'h10, d);
        rd(EAC_OFS_CONTROL, {2'h0, m, 4'h2});
        wr(EAC_OFS_CONTROL, 8'h30);
        wr(EAC_OFS_ADDR_LOW, 8'h77);
        rd(EAC_OFS_CONTROL, {2'h0, m, 4'h2});
        rd(EAC_OFS_ADDR_LOW, 8'h10);
        `CHK(grant, 1'b0)
        finish(t);
        `CHK(grant, 1'b1)
        // busy is clear here, so the read may go ahead
        wr(EAC_OFS_CONTROL, 8'h01);
        rd(EAC_OFS_DATA, e);
    endtask : prog
    initial begin
        {io_wr_en, io_rd_en, irq_g, io_addr, io_wdata} = '0;
        {resetn, por_resetn, freq} = 3'h1;
        repeat (12) @(posedge clk);
        {resetn, por_resetn} <= 2'h3;
        foreach (rows[i]) rd(rows[i][21:16], 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][21:16], rows[i][15:8]);
            rd(rows[i][21:16], rows[i][7:0]);
        end
        foreach (rows[i]) if (i < 2) begin
            wr(EAC_OFS_ADDR_LOW, 8'(i * 255));
            wr(EAC_OFS_CONTROL, 8'h01);
            `CHK(cpu_stall, 1'b1)
            `CHK(ee_rd_stb, 1'b1)
            rd(EAC_OFS_DATA, 8'(i * 255) ^ 8'ha5);
        end
        wr(EAC_OFS_CONTROL, 8'h02);
        `CHK(blocked, 1'b0)
        wr(EAC_OFS_CONTROL, 8'h04);
        rd(EAC_OFS_CONTROL, 8'h04);
        repeat (3) @(posedge clk);
        rd(EAC_OFS_CONTROL, 8'h00);
        wr(EAC_OFS_CONTROL, 8'h04);
        repeat (4) @(posedge clk);
        wr(EAC_OFS_CONTROL, 8'h06);
        `CHK(blocked, 1'b0)
        wr(EAC_OFS_CONTROL, 8'h34);
        wr(EAC_OFS_CONTROL, 8'h36);
        `CHK(blocked, 1'b0)
        freq <= 1'b1;
        prog(2'h0, 20, 8'h3c, 8'h3c);
        prog(2'h1, 10, 8'h00, 8'hff);
        prog(2'h2, 10, 8'h81, 8'h81);
        start(2'h1, 8'h20, 8'h00);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(EAC_OFS_CONTROL, 8'h12);
        finish(10);
        rd(EAC_OFS_ADDR_LOW, 8'h20);
        wr(EAC_OFS_CONTROL, 8'h18);
        irq_g <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(ready_irq, 1'b1)
        irq_g <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(ready_irq, 1'b0)
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        rd(EAC_OFS_CONTROL, 8'h00);
        tally_and_finish();
    end
    initial begin
        #1000000;
        miscompares++;
        tally_and_finish();
    end
endmodule : eeprom_access_controller_tb
`default_nettype wire
